// ### hdl/leis_regs.sv
`timescale 1ns/10ps
`include "leis_defines.svh"
module leis_regs #(
   parameter logic [7:0] DEVICE_ID  = 8'h5a, // Arbitrary value
   parameter logic [3:0] REVISION   = 4'h1,  // Arbitrary value
   parameter logic       CP_CAPABLE = 1'b0,
   parameter int         RATE0      = `LEIS_RATE0_BITS,
   parameter int         RATE1      = `LEIS_RATE1_BITS,
   parameter int         RATE2      = `LEIS_RATE2_BITS,
   parameter int         RATE3      = `LEIS_RATE3_BITS
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        coax_strap_level,
   input  wire logic        control_port_select_strap,
   input  wire logic        local_control_channel_strap,
   input  wire logic        serial_output_active,
   input  wire logic        parallel_input_clock_valid,
   input  wire logic        ser_bit_valid,
   input  wire logic        ser_bit_in,
   output logic             ser_bit_out,
   output logic             ser_bit_out_valid
);
   logic [7:0]  ctrl, next_ctrl;
   logic [2:0]  straps, next_straps;
   logic        strap_taken, next_strap_taken;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic        wr_ctrl;
   logic        inj_busy;
   logic        inj_done;
   logic [7:0]  idx;
   logic [7:0]  status;

   assign idx     = paddr[9:2];
   assign wr_ctrl = psel && penable && pready && pwrite && idx == `LEIS_IDX_CTRL && paddr[11:10] == 2'b00;

   // Status word; strap inputs read inverted where they are active low
   always_comb begin
      status                   = 8'h00;
      status[`LEIS_ST_COAX]    = straps[2];
      status[`LEIS_ST_PORTSEL] = straps[1];
      status[`LEIS_ST_LCC]     = straps[0];
      status[`LEIS_ST_OUTEN]   = serial_output_active;
      status[`LEIS_ST_PCLK]    = !parallel_input_clock_valid;
   end

   // Map lookup, shared by read data and the error answer
   function automatic logic map_hit(input logic [11:0] a);
      case (a[9:2])
         `LEIS_IDX_CTRL, `LEIS_IDX_RSVD_A, `LEIS_IDX_RSVD_B, `LEIS_IDX_RSVD_C,
         `LEIS_IDX_STATUS, `LEIS_IDX_RSVD_D, `LEIS_IDX_RSVD_E, `LEIS_IDX_INJ_STAT,
         `LEIS_IDX_ID, `LEIS_IDX_CAPREV: map_hit = (a[11:10] == 2'b00);
         default: map_hit = 1'b0;
      endcase
   endfunction

   // One wait state: answer is prepared in the first access cycle
   always_comb begin
      next_pready  = psel && penable && !pready;
      next_pslverr = 1'b0;
      next_prdata  = prdata;
      if (psel && penable && !pready) begin
         next_pslverr = !map_hit(paddr);
         next_prdata  = 32'h00000000;
         if (!pwrite && map_hit(paddr)) begin
            case (idx)
               `LEIS_IDX_CTRL:     next_prdata[7:0] = ctrl;
               `LEIS_IDX_RSVD_A:   next_prdata[7:0] = `LEIS_RST_RSVD_A;
               `LEIS_IDX_RSVD_B:   next_prdata[7:0] = `LEIS_RST_RSVD_B;
               `LEIS_IDX_STATUS:   next_prdata[7:0] = status;
               `LEIS_IDX_INJ_STAT: next_prdata[7:0] = {6'h00, inj_done, inj_busy};
               `LEIS_IDX_ID:       next_prdata[7:0] = DEVICE_ID;
               `LEIS_IDX_CAPREV:   next_prdata[7:0] = {3'b000, CP_CAPABLE, REVISION};
               default:            next_prdata[7:0] = `LEIS_RST_RSVD_0;
            endcase
         end
      end
   end

   // Control register; reserved words ignore writes
   always_comb begin
      next_ctrl = ctrl;
      if (wr_ctrl) begin
         next_ctrl = pwdata[7:0];
      end
   end

   // Straps are caught once, on the first edge after reset release
   always_comb begin
      next_straps      = straps;
      next_strap_taken = 1'b1;
      if (!strap_taken) begin
         next_straps = {coax_strap_level, !control_port_select_strap, !local_control_channel_strap};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl        <= `LEIS_RST_CTRL;
         straps      <= 3'b000;
         strap_taken <= 1'b0;
         prdata      <= 32'h00000000;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
      end else begin
         ctrl        <= next_ctrl;
         straps      <= next_straps;
         strap_taken <= next_strap_taken;
         prdata      <= next_prdata;
         pready      <= next_pready;
         pslverr     <= next_pslverr;
      end
   end

   // Any control write restarts the engine so new fields apply cleanly
   leis_injector #(
      .RATE0 (RATE0),
      .RATE1 (RATE1),
      .RATE2 (RATE2),
      .RATE3 (RATE3)
   ) u_injector (
      .pclk          (pclk),
      .presetn       (presetn),
      .enable        (ctrl[`LEIS_CTRL_EN]),
      .periodic      (ctrl[`LEIS_CTRL_PER]),
      .rate          (ctrl[`LEIS_CTRL_RATE_LO +: 2]),
      .itype         (ctrl[`LEIS_CTRL_TYPE_LO +: 2]),
      .icount        (ctrl[`LEIS_CTRL_CNT_LO +: 2]),
      .restart       (wr_ctrl),
      .bit_valid     (ser_bit_valid),
      .bit_in        (ser_bit_in),
      .bit_out       (ser_bit_out),
      .bit_out_valid (ser_bit_out_valid),
      .busy          (inj_busy),
      .done          (inj_done)
   );

   // Status bit zero follows the inverted clock detector
   property p_pclk_status;
      @(posedge pclk) disable iff (!presetn)
      psel && penable && pready && !pwrite && paddr == {2'b00, `LEIS_IDX_STATUS, 2'b00}
         |-> prdata[0] == !$past(parallel_input_clock_valid);
   endproperty
   a_pclk_status: assert property (p_pclk_status) else $error("clock detect bit wrong");

   property p_disabled_clean;
      @(posedge pclk) disable iff (!presetn)
      !ctrl[`LEIS_CTRL_EN] |=> ser_bit_out == $past(ser_bit_in);
   endproperty
   a_disabled_clean: assert property (p_disabled_clean) else $error("bit corrupted while disabled");

   property p_ctrl_write;
      @(posedge pclk) disable iff (!presetn)
      wr_ctrl |=> ctrl == $past(pwdata[7:0]) && !inj_done;
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control write not taken");

   property p_rate_reset;
      @(posedge pclk) disable iff (!presetn)
      $rose(strap_taken) |-> ctrl == `LEIS_RST_CTRL;
   endproperty
   a_rate_reset: assert property (p_rate_reset) else $error("control reset value wrong");

   property p_one_wait;
      @(posedge pclk) disable iff (!presetn)
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("answer timing wrong");

   // Clearing the enable parks the engine within one cycle
   property p_disabled_idle;
      @(posedge pclk) disable iff (!presetn)
      !ctrl[`LEIS_CTRL_EN] |=> !inj_busy;
   endproperty
   a_disabled_idle: assert property (p_disabled_idle) else $error("engine busy while disabled");

   // A finished run leaves the stream untouched until rewritten
   property p_done_quiet;
      @(posedge pclk) disable iff (!presetn)
      inj_done |=> ser_bit_out == $past(ser_bit_in);
   endproperty
   a_done_quiet: assert property (p_done_quiet) else $error("bit corrupted after run finished");

   // Control fields change only through a bus write to them
   property p_ctrl_hold;
      @(posedge pclk) disable iff (!presetn)
      !wr_ctrl |=> ctrl == $past(ctrl);
   endproperty
   a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed without a write");

   // Error answer only for addresses outside the map
   property p_err_answer;
      @(posedge pclk) disable iff (!presetn)
      psel && penable && pready |-> pslverr == !map_hit(paddr);
   endproperty
   a_err_answer: assert property (p_err_answer) else $error("error answer wrong");

   // Registers are one byte wide, upper read bits stay zero
   property p_read_upper;
      @(posedge pclk) disable iff (!presetn)
      psel && penable && pready && !pwrite |-> prdata[31:8] == 24'h000000;
   endproperty
   a_read_upper: assert property (p_read_upper) else $error("upper read bits not zero");

   // Bit strobe passes through with one cycle of latency
   property p_valid_pass;
      @(posedge pclk) disable iff (!presetn)
      ser_bit_valid |=> ser_bit_out_valid;
   endproperty
   a_valid_pass: assert property (p_valid_pass) else $error("bit strobe lost");
endmodule

// ### include/leis_defines.svh
// How it works
// - Rate field picks 2560/40960/655360/10485760-bit interval
// - Type field: single bit, or 2-4 symbols
// - Bit 1 periodic; count field continuous/16/128/1024
// - Status bit 0 reads 1 without pixel clock
`ifndef LEIS_DEFINES_SVH
`define LEIS_DEFINES_SVH

// Register indexes; byte address is four times the index
`define LEIS_IDX_CTRL      8'h11
`define LEIS_IDX_RSVD_A    8'h12
`define LEIS_IDX_RSVD_B    8'h13
`define LEIS_IDX_RSVD_C    8'h14
`define LEIS_IDX_STATUS    8'h15
`define LEIS_IDX_RSVD_D    8'h16
`define LEIS_IDX_RSVD_E    8'h17
`define LEIS_IDX_INJ_STAT  8'h18
`define LEIS_IDX_ID        8'h1e
`define LEIS_IDX_CAPREV    8'h1f

// Reset values
`define LEIS_RST_CTRL      8'h00
`define LEIS_RST_RSVD_A    8'h40
`define LEIS_RST_RSVD_B    8'h22
`define LEIS_RST_RSVD_0    8'h00

// Control field positions
`define LEIS_CTRL_EN       0
`define LEIS_CTRL_PER      1
`define LEIS_CTRL_CNT_LO   2
`define LEIS_CTRL_TYPE_LO  4
`define LEIS_CTRL_RATE_LO  6

// Status field positions
`define LEIS_ST_PCLK       0
`define LEIS_ST_OUTEN      1
`define LEIS_ST_LCC        5
`define LEIS_ST_PORTSEL    6
`define LEIS_ST_COAX       7

// Interval lengths in serial bits, error totals, symbol length
`define LEIS_RATE0_BITS    2560
`define LEIS_RATE1_BITS    40960
`define LEIS_RATE2_BITS    655360
`define LEIS_RATE3_BITS    10485760
`define LEIS_TOTAL1        16
`define LEIS_TOTAL2        128
`define LEIS_TOTAL3        1024
`define LEIS_SYM_BITS      10

`endif

// ### include/leis_pkg.sv
package leis_pkg;
   // Injection engine states, one-hot
   typedef enum logic [2:0] {
      LEIS_IDLE    = 3'b001,
      LEIS_WAIT    = 3'b010,
      LEIS_CORRUPT = 3'b100
   } leis_state_t;
endpackage

// ### hdl/leis_injector.sv
`timescale 1ns/10ps
`include "leis_defines.svh"
module leis_injector #(
   parameter int RATE0 = `LEIS_RATE0_BITS,
   parameter int RATE1 = `LEIS_RATE1_BITS,
   parameter int RATE2 = `LEIS_RATE2_BITS,
   parameter int RATE3 = `LEIS_RATE3_BITS
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       enable,
   input  wire logic       periodic,
   input  wire logic [1:0] rate,
   input  wire logic [1:0] itype,
   input  wire logic [1:0] icount,
   input  wire logic       restart,
   input  wire logic       bit_valid,
   input  wire logic       bit_in,
   output logic            bit_out,
   output logic            bit_out_valid,
   output logic            busy,
   output logic            done
);
   leis_pkg::leis_state_t st, next_st;
   logic [23:0] ivl_cnt, next_ivl_cnt;
   logic [3:0]  pos, next_pos;
   logic [1:0]  sym_left, next_sym_left;
   logic [10:0] err_cnt, next_err_cnt;
   logic        next_done;
   logic        flip_now;
   logic        ivl_hit;

   // Interval length for a rate code
   function automatic logic [23:0] interval(input logic [1:0] r);
      case (r)
         2'b00:   interval = 24'(RATE0);
         2'b01:   interval = 24'(RATE1);
         2'b10:   interval = 24'(RATE2);
         default: interval = 24'(RATE3);
      endcase
   endfunction

   // Error total for a count code; zero means run on
   function automatic logic [10:0] limit(input logic [1:0] c);
      case (c)
         2'b01:   limit = 11'(`LEIS_TOTAL1);
         2'b10:   limit = 11'(`LEIS_TOTAL2);
         2'b11:   limit = 11'(`LEIS_TOTAL3);
         default: limit = 11'h000;
      endcase
   endfunction

   assign ivl_hit = (ivl_cnt == interval(rate) - 24'h000001);

   // Sequencing of interval wait and symbol corruption
   always_comb begin
      next_st       = st;
      next_ivl_cnt  = ivl_cnt;
      next_pos      = pos;
      next_sym_left = sym_left;
      next_err_cnt  = err_cnt;
      next_done     = done;
      flip_now      = 1'b0;
      if (restart || !enable) begin
         next_st      = leis_pkg::LEIS_IDLE;
         next_ivl_cnt = 24'h000000;
         if (restart) begin
            next_done    = 1'b0;
            next_err_cnt = 11'h000;
         end
      end else begin
         case (st)
            leis_pkg::LEIS_IDLE: begin
               if (!done) begin
                  next_st      = leis_pkg::LEIS_WAIT;
                  next_ivl_cnt = 24'h000000;
               end
            end
            leis_pkg::LEIS_WAIT: begin
               if (bit_valid) begin
                  next_ivl_cnt = ivl_cnt + 24'h000001;
                  if (ivl_hit) begin
                     flip_now      = 1'b1;
                     next_pos      = 4'h0;
                     next_sym_left = itype;
                     next_st       = (itype == 2'b00) ? leis_pkg::LEIS_WAIT : leis_pkg::LEIS_CORRUPT;
                  end
               end
            end
            leis_pkg::LEIS_CORRUPT: begin
               if (bit_valid) begin
                  next_pos = pos + 4'h1;
                  if (pos == 4'(`LEIS_SYM_BITS - 1)) begin
                     flip_now      = 1'b1;
                     next_pos      = 4'h0;
                     next_sym_left = sym_left - 2'b01;
                     if (sym_left == 2'b01) begin
                        next_st = leis_pkg::LEIS_WAIT;
                     end
                  end
               end
            end
            default: next_st = leis_pkg::LEIS_IDLE;
         endcase
         // One error finishes when its last flip lands in the wait state
         if (flip_now && next_st == leis_pkg::LEIS_WAIT) begin
            next_err_cnt = err_cnt + 11'h001;
            next_ivl_cnt = 24'h000000;
            if (!periodic || (icount != 2'b00 && next_err_cnt == limit(icount))) begin
               next_done = 1'b1;
               next_st   = leis_pkg::LEIS_IDLE;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st            <= leis_pkg::LEIS_IDLE;
         ivl_cnt       <= 24'h000000;
         pos           <= 4'h0;
         sym_left      <= 2'b00;
         err_cnt       <= 11'h000;
         done          <= 1'b0;
         busy          <= 1'b0;
         bit_out       <= 1'b0;
         bit_out_valid <= 1'b0;
      end else begin
         st            <= next_st;
         ivl_cnt       <= next_ivl_cnt;
         pos           <= next_pos;
         sym_left      <= next_sym_left;
         err_cnt       <= next_err_cnt;
         done          <= next_done;
         busy          <= (next_st != leis_pkg::LEIS_IDLE);
         bit_out       <= bit_in ^ flip_now;
         bit_out_valid <= bit_valid;
      end
   end

   property p_ivl_bound;
      @(posedge pclk) disable iff (!presetn)
      st == leis_pkg::LEIS_WAIT |-> ivl_cnt < interval(rate);
   endproperty
   a_ivl_bound: assert property (p_ivl_bound) else $error("interval counter overran");

   property p_corrupt_type;
      @(posedge pclk) disable iff (!presetn)
      st == leis_pkg::LEIS_CORRUPT |-> itype != 2'b00 && sym_left != 2'b00;
   endproperty
   a_corrupt_type: assert property (p_corrupt_type) else $error("symbol corruption for single-bit type");

   property p_count_limit;
      @(posedge pclk) disable iff (!presetn)
      $rose(done) && periodic && icount != 2'b00 |-> err_cnt == limit(icount);
   endproperty
   a_count_limit: assert property (p_count_limit) else $error("error total wrong at stop");
endmodule

// ### verification/tb.sv
`timescale 1ns/10ps
`include "leis_defines.svh"
module tb;
   localparam int R0 = 12, R1 = 16, R2 = 20, R3 = 24;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic        pready, pslverr, errv;
   logic        coax = 1'b1, psel_strap = 1'b0, lcc = 1'b1, out_act = 1'b0, pck_ok = 1'b1;
   logic        sbv = 1'b0, sbi = 1'b0, sbo, sbov, d1 = 1'b0;
   int          n_fail = 0, n_checks = 0, n_flip = 0, bit_idx = 0, last_pos = 0, gap = 0;

   // Small intervals keep each scenario short; arbitrary identity values
   leis_regs #(.DEVICE_ID(8'h3c), .REVISION(4'h2), .CP_CAPABLE(1'b1),
      .RATE0(R0), .RATE1(R1), .RATE2(R2), .RATE3(R3)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .coax_strap_level(coax), .control_port_select_strap(psel_strap),
      .local_control_channel_strap(lcc), .serial_output_active(out_act),
      .parallel_input_clock_valid(pck_ok), .ser_bit_valid(sbv), .ser_bit_in(sbi),
      .ser_bit_out(sbo), .ser_bit_out_valid(sbov));

   always #20 pclk = ~pclk;

   // Serial stream: one bit each cycle, a pattern that toggles except while bit_idx[2] is set, when it holds
   always @(posedge pclk) begin
      sbv <= presetn;
      sbi <= ~sbi ^ bit_idx[2];
      d1 <= sbi;
      if (presetn && sbov === 1'b1) begin
         bit_idx <= bit_idx + 1;
         if (sbo !== d1) begin
            n_flip <= n_flip + 1;
            gap <= bit_idx - last_pos;
            last_pos <= bit_idx;
         end
      end
   end

   task automatic final_report();
      if (n_fail == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; waits for pready, no fixed latency assumed
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [11:0] ad(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

   task automatic wr_ctrl(input logic [7:0] v);
      apb(1'b1, ad(`LEIS_IDX_CTRL), {24'h0, v});
   endtask

   task automatic wait_done(input int bound);
      int k;
      k = 0;
      apb(1'b0, ad(`LEIS_IDX_INJ_STAT), 32'h0);
      while (rdv[1] !== 1'b1 && k < bound) begin
         apb(1'b0, ad(`LEIS_IDX_INJ_STAT), 32'h0);
         k++;
      end
   endtask

   // Reset values, read-only places and refused addresses
   task automatic t_regs();
      logic [7:0] idx [8] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h16, 8'h17, 8'h1e, 8'h1f};
      logic [7:0] exv [8] = '{8'h00, 8'h40, 8'h22, 8'h00, 8'h00, 8'h00, 8'h3c, 8'h12};
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, ad(idx[i]), 32'h0);
         chk("reset value", rdv, {24'h0, exv[i]});
         chk("mapped no error", {31'h0, errv}, 32'h0);
         apb(1'b1, ad(idx[i]), 32'hffff_ffbe);
      end
      apb(1'b0, ad(8'h12), 32'h0);
      chk("reserved after write", rdv, 32'h40);
      apb(1'b0, ad(8'h10), 32'h0);
      chk("unmapped error", {31'h0, errv}, 32'h1);
      chk("unmapped data", rdv, 32'h0);
      apb(1'b0, 12'h444, 32'h0);
      chk("high page error", {31'h0, errv}, 32'h1);
      wr_ctrl(8'h00);
   endtask

   // Straps frozen, output state and pixel clock read live
   task automatic t_status();
      for (int i = 0; i < 4; i++) begin
         @(posedge pclk);
         out_act <= i[0];
         pck_ok <= i[1];
         coax <= 1'b0;
         repeat (2) @(posedge pclk);
         apb(1'b0, ad(`LEIS_IDX_STATUS), 32'h0);
         chk("status", rdv, {24'h0, 3'b110, 3'b000, i[0], ~i[1]});
      end
   endtask

   // Enable clear: no flips with every other field set to ones
   task automatic t_disabled();
      int base;
      wr_ctrl(8'hfe);
      base = n_flip;
      repeat (4 * R3) @(posedge pclk);
      chk("disabled flips", n_flip - base, 0);
   endtask

   // Every rate code: spacing of single-bit errors
   task automatic t_rate();
      int rates [4] = '{R0, R1, R2, R3};
      int base;
      for (int r = 0; r < 4; r++) begin
         wr_ctrl({r[1:0], 6'b000011});
         base = n_flip;
         repeat (5 * R3) @(posedge pclk);
         chk("flips in run", n_flip - base > 2, 1);
         chk("interval", gap, rates[r]);
         wr_ctrl(8'h00);
         // A flip launched just before the write may still be in flight
         repeat (2) @(posedge pclk);
         base = n_flip;
         repeat (2 * R3) @(posedge pclk);
         chk("stop on clear", n_flip - base, 0);
      end
   endtask

   // Every type code, one-shot mode
   task automatic t_type();
      int base;
      for (int t = 0; t < 4; t++) begin
         base = n_flip;
         wr_ctrl({2'b00, t[1:0], 4'b0001});
         wait_done(200);
         repeat (3 * R0) @(posedge pclk);
         chk("one-shot done", rdv, 32'h2);
         chk("type flips", n_flip - base, t + 1);
         if (t > 0) chk("symbol spacing", gap, `LEIS_SYM_BITS);
         wr_ctrl(8'h00);
      end
   endtask

   // Every count code in periodic mode
   task automatic t_count();
      int tot [4] = '{0, `LEIS_TOTAL1, `LEIS_TOTAL2, `LEIS_TOTAL3};
      int base;
      for (int c = 1; c < 4; c++) begin
         base = n_flip;
         wr_ctrl({4'b0000, c[1:0], 2'b11});
         wait_done(tot[c] * R0);
         repeat (3 * R0) @(posedge pclk);
         chk("count total", n_flip - base, tot[c]);
      end
      base = n_flip;
      wr_ctrl(8'h03);
      repeat (20 * R0 + 20) @(posedge pclk);
      chk("continuous", n_flip - base > `LEIS_TOTAL1, 1);
      apb(1'b0, ad(`LEIS_IDX_INJ_STAT), 32'h0);
      chk("continuous busy", rdv, 32'h1);
      wr_ctrl(8'h00);
   endtask

   // Reset in mid-run: control back to zero, engine idle, stream clean
   task automatic t_reset();
      int base;
      wr_ctrl(8'h03);
      repeat (3 * R0) @(posedge pclk);
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      base = n_flip;
      apb(1'b0, ad(`LEIS_IDX_CTRL), 32'h0);
      chk("ctrl after reset", rdv, 32'h0);
      apb(1'b0, ad(`LEIS_IDX_INJ_STAT), 32'h0);
      chk("engine after reset", rdv, 32'h0);
      repeat (4 * R3) @(posedge pclk);
      chk("flips after reset", n_flip - base, 0);
   endtask

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_status();
      t_disabled();
      t_rate();
      t_type();
      t_count();
      t_reset();
      final_report();
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (80000) @(posedge pclk);
      n_fail++;
      final_report();
   end
endmodule
